// ===== hdl/pfu_unpacker.v
/*
 Pixel format unpacker: APB register slave, gamma table, and a word-to-pixel
 stream stage for monochrome passive packing and second overlay alpha formats.
 Assumes one clock, 16-bit display buffer words with valid/ready, and a
 downstream pixel sink with valid/ready.
*/
// Contract
// (RULE_01) Colour passive panel when panel kind bit 14 is 1 and type is 010.
// (RULE_02) Colour passive without gamma: only component bits 7:2 reach the panel.
// (RULE_03) With gamma: index by all eight bits, send lookup bits 7:2 only.
// (RULE_04) Monochrome passive at 8, 16, 32 bpp shows at most 64 gray levels.
// (RULE_05) Monochrome data is D[7:0]; only D[7:2] displayed unless gamma indexes.
// (RULE_06) Mono 8 bpp: even pixel bits 7:0, odd pixel bits 15:8.
// (RULE_07) Mono 16 bpp: D7-5 bits 15:13, D4-2 bits 10:8, D1-0 bits 4:3.
// (RULE_08) Mono 32 bpp: first word D4-2, D1-0; second word bits 7:5 D7-5.
// (RULE_09) Second overlay may use alpha formats besides plain 8/16/32 bpp.
// (RULE_10) Overlay alpha flag bit 11 selects alpha formats versus plain colour.
// (RULE_11) Overlay depth field bits 10:8 with alpha flag picks the format.
// (RULE_12) 1:5:5:5: alpha bit 15, red 14:10, green 9:5, blue 4:0.
// (RULE_13) 4:4:4:4: alpha 15:12, red 11:8, green 7:4, blue 3:0.
// (RULE_14) 32-bit alpha: first word green, blue; second word alpha, red.
// (RULE_15) Main depth bits 2:0, first overlay depth bits 6:4, among 8/16/32.
// (RULE_16) Components leave left-aligned in 8 bits, low bits zero.
`include "pfu_defines.vh"

module pfu_unpacker (
   // Clock and reset
   input  wire        core_clk,
   input  wire        rst,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output reg  [31:0] prdata,
   output wire        pslverr,
   // Display buffer words
   input  wire        word_valid,
   input  wire [15:0] word_data,
   output wire        word_ready,
   // Unpacked pixels to blending
   output reg         pix_valid,
   input  wire        pix_ready,
   output reg  [7:0]  pix_alpha,
   output reg  [7:0]  pix_red,
   output reg  [7:0]  pix_green,
   output reg  [7:0]  pix_blue,
   // Panel values after truncation or gamma
   output reg  [5:0]  disp_red,
   output reg  [5:0]  disp_green,
   output reg  [5:0]  disp_blue
);

   reg  [15:0] panel_cfg;
   reg  [15:0] disp_mode;
   reg  [7:0]  control;
   reg  [7:0]  gamma_idx;
   reg  [15:0] pix_count;
   reg  [7:0]  gamma_lookup_table [0:`PFU_GAM_DEPTH-1];

   reg         phase;
   reg  [15:0] held_word;

   wire        setup     = psel & ~penable;
   wire        access    = psel & penable;

   // One hit per register keeps write, read and error decode in step
   wire        hit_panel = (paddr == `PFU_OFF_PANEL_CFG);
   wire        hit_mode  = (paddr == `PFU_OFF_DISP_MODE);
   wire        hit_ctl   = (paddr == `PFU_OFF_CONTROL);
   wire        hit_stat  = (paddr == `PFU_OFF_STATUS);
   wire        hit_gam   = (paddr == `PFU_OFF_GAMMA);
   wire        hit_cnt   = (paddr == `PFU_OFF_PIX_COUNT);
   wire        mapped    = hit_panel | hit_mode | hit_ctl | hit_stat | hit_gam | hit_cnt;
   wire        wr_en     = access & pwrite & mapped;
   wire        mode_wr   = wr_en & (hit_panel | hit_mode | hit_ctl);
   wire        gam_wr    = wr_en & hit_gam;

   // Zero wait states; unmapped addresses answer with an error
   assign pready  = 1'b1;
   assign pslverr = access & ~mapped;

   // Panel classification
   wire        passive_type = (panel_cfg[`PFU_PANEL_TYPE_HI:`PFU_PANEL_TYPE_LO] == `PFU_PANEL_TYPE_PASSIVE);
   wire        colour_passive = panel_cfg[`PFU_PANEL_KIND_BIT] & passive_type; // RULE_01
   wire        mono_passive   = ~panel_cfg[`PFU_PANEL_KIND_BIT] & passive_type;
   wire        gamma_en       = control[`PFU_CTL_GAMMA_BIT];
   wire [1:0]  win_sel        = control[`PFU_CTL_WIN_HI:`PFU_CTL_WIN_LO];
   wire        alpha_flag     = disp_mode[`PFU_ALPHA_FLAG_BIT];

   // Depth of the window currently being fetched
   reg  [2:0]  depth;
   always @* begin
      case (win_sel)
         `PFU_WIN_MAIN: depth = disp_mode[`PFU_MAIN_DEPTH_HI:`PFU_MAIN_DEPTH_LO]; // RULE_15
         `PFU_WIN_OVL1: depth = disp_mode[`PFU_OVL1_DEPTH_HI:`PFU_OVL1_DEPTH_LO]; // RULE_15
         `PFU_WIN_OVL2: depth = disp_mode[`PFU_OVL2_DEPTH_HI:`PFU_OVL2_DEPTH_LO]; // RULE_11
         default:       depth = disp_mode[`PFU_MAIN_DEPTH_HI:`PFU_MAIN_DEPTH_LO];
      endcase
   end

   // Format selection; alpha formats only for the second overlay
   reg  [2:0]  fmt;
   always @* begin
      fmt = `PFU_FMT_NONE;
      if ((win_sel == `PFU_WIN_OVL2) && alpha_flag) begin // RULE_09 RULE_10
         case (depth) // RULE_11
            `PFU_DEPTH_8:  fmt = `PFU_FMT_A1555;
            `PFU_DEPTH_16: fmt = `PFU_FMT_A4444;
            `PFU_DEPTH_32: fmt = `PFU_FMT_A8888;
            default:       fmt = `PFU_FMT_NONE;
         endcase
      end else if (mono_passive) begin
         case (depth)
            `PFU_DEPTH_8:  fmt = `PFU_FMT_MONO8;
            `PFU_DEPTH_16: fmt = `PFU_FMT_MONO16;
            `PFU_DEPTH_32: fmt = `PFU_FMT_MONO32;
            default:       fmt = `PFU_FMT_NONE;
         endcase
      end
   end

   // Packing class of the current format
   wire        two_word  = (fmt == `PFU_FMT_MONO32) | (fmt == `PFU_FMT_A8888);
   wire        two_pixel = (fmt == `PFU_FMT_MONO8);
   wire        out_free  = ~pix_valid | pix_ready;

   // Stream handshake: first half of a two-word pixel is stashed freely,
   // while a pending odd mono pixel blocks new words
   reg         take_ok;
   always @* begin
      if (two_pixel) begin
         take_ok = ~phase & out_free;
      end else if (two_word & ~phase) begin
         take_ok = 1'b1;
      end else begin
         take_ok = out_free;
      end
   end
   assign word_ready = take_ok;

   wire        word_take = word_valid & word_ready;
   wire        emit_word = word_take & ~(two_word & ~phase);
   wire        emit_odd  = two_pixel & phase & out_free;
   wire        emit      = emit_word | emit_odd;

   // Gray per monochrome packing; low two bits kept for the gamma index
   wire [7:0]  gray8  = phase ? held_word[15:8] : word_data[7:0]; // RULE_06
   wire [7:0]  gray16 = {word_data[15:13], word_data[10:8], word_data[4:3]}; // RULE_07
   wire [7:0]  gray32 = {word_data[7:5], held_word[15:13], held_word[7:6]}; // RULE_08

   // Component extraction
   reg  [7:0]  next_alpha;
   reg  [7:0]  next_red;
   reg  [7:0]  next_green;
   reg  [7:0]  next_blue;
   reg  [7:0]  gray;
   always @* begin
      gray       = 8'h00;
      next_alpha = 8'h00;
      next_red   = 8'h00;
      next_green = 8'h00;
      next_blue  = 8'h00;
      case (fmt)
         `PFU_FMT_MONO8:
            gray = gray8;
         `PFU_FMT_MONO16:
            gray = gray16;
         `PFU_FMT_MONO32:
            gray = gray32;
         `PFU_FMT_A1555: begin // RULE_12 RULE_16
            next_alpha = {word_data[15], 7'h00};
            next_red   = {word_data[14:10], 3'h0};
            next_green = {word_data[9:5], 3'h0};
            next_blue  = {word_data[4:0], 3'h0};
         end
         `PFU_FMT_A4444: begin // RULE_13 RULE_16
            next_alpha = {word_data[15:12], 4'h0};
            next_red   = {word_data[11:8], 4'h0};
            next_green = {word_data[7:4], 4'h0};
            next_blue  = {word_data[3:0], 4'h0};
         end
         `PFU_FMT_A8888: begin // RULE_14
            next_green = held_word[15:8];
            next_blue  = held_word[7:0];
            next_alpha = word_data[15:8];
            next_red   = word_data[7:0];
         end
         default: begin
            gray = 8'h00;
         end
      endcase
      if (mono_passive && (fmt == `PFU_FMT_MONO8 || fmt == `PFU_FMT_MONO16 || fmt == `PFU_FMT_MONO32)) begin
         next_alpha = 8'hFF;
         next_red   = gray;
         next_green = gray;
         next_blue  = gray;
      end
   end

   // Panel lanes; gamma only applies to passive panels
   wire [23:0] lane_in  = {next_red, next_green, next_blue};
   wire [17:0] lane_out;
   wire        lane_gamma = gamma_en & (colour_passive | mono_passive);
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_lane
         wire [7:0] comp_byte = lane_in[gi*8 +: 8];
         // Full eight bits index the table
         wire [7:0] lut_byte  = gamma_lookup_table[comp_byte]; // RULE_03
         pfu_lane u_lane (
            .comp     (comp_byte),
            .lut_out  (lut_byte),
            .gamma_en (lane_gamma),
            .disp     (lane_out[gi*6 +: 6])
         );
      end
   endgenerate

   // Stream state
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         phase     <= 1'b0;
         held_word <= 16'h0000;
      end else if (mode_wr) begin
         // A format change drops any half-built pixel
         phase     <= 1'b0;
      end else if (two_word) begin
         if (word_take) begin
            phase <= ~phase;
            if (!phase) begin
               held_word <= word_data;
            end
         end
      end else if (two_pixel) begin
         if (emit_odd) begin
            phase <= 1'b0;
         end else if (word_take) begin
            phase     <= 1'b1;
            held_word <= word_data;
         end
      end else begin
         phase <= 1'b0;
      end
   end

   // Output pixel register
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pix_valid  <= 1'b0;
         pix_alpha  <= 8'h00;
         pix_red    <= 8'h00;
         pix_green  <= 8'h00;
         pix_blue   <= 8'h00;
      end else begin
         if (emit) begin
            pix_valid  <= 1'b1;
            pix_alpha  <= next_alpha;
            pix_red    <= next_red;
            pix_green  <= next_green;
            pix_blue   <= next_blue;
         end else if (pix_ready) begin
            pix_valid <= 1'b0;
         end
      end
   end

   // Panel values load with their pixel, so both stall together
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         disp_red   <= 6'h00;
         disp_green <= 6'h00;
         disp_blue  <= 6'h00;
      end else if (emit) begin
         disp_red   <= lane_out[17:12]; // RULE_02 RULE_04
         disp_green <= lane_out[11:6];
         disp_blue  <= lane_out[5:0];
      end
   end

   // Pixel counter wraps at 16 bits; software reads differences
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pix_count <= 16'h0000;
      end else if (emit) begin
         pix_count <= pix_count + 16'h0001;
      end
   end

   // Register writes
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         panel_cfg <= `PFU_RST_PANEL_CFG;
         disp_mode <= `PFU_RST_DISP_MODE;
         control   <= `PFU_RST_CONTROL;
         gamma_idx <= 8'h00;
      end else if (wr_en) begin
         case (paddr)
            `PFU_OFF_PANEL_CFG: panel_cfg <= pwdata[15:0];
            `PFU_OFF_DISP_MODE: disp_mode <= pwdata[15:0];
            `PFU_OFF_CONTROL:   control   <= pwdata[7:0];
            `PFU_OFF_GAMMA:     gamma_idx <= pwdata[`PFU_GAM_IDX_HI:`PFU_GAM_IDX_LO];
            default:            control   <= control;
         endcase
      end
   end

   // Gamma table has no reset; software loads it before use
   always @(posedge core_clk) begin
      if (gam_wr) begin
         gamma_lookup_table[pwdata[`PFU_GAM_IDX_HI:`PFU_GAM_IDX_LO]] <=
            pwdata[`PFU_GAM_VAL_HI:`PFU_GAM_VAL_LO]; // RULE_03
      end
   end

   // Status word
   wire [7:0]  status_word = {pix_valid, phase, mono_passive, colour_passive, 1'b0, fmt};

   // Read mux; unmapped offsets read as zero
   reg  [31:0] next_prdata;
   always @* begin
      case (paddr)
         `PFU_OFF_PANEL_CFG: next_prdata = {16'h0000, panel_cfg};
         `PFU_OFF_DISP_MODE: next_prdata = {16'h0000, disp_mode};
         `PFU_OFF_CONTROL:   next_prdata = {24'h000000, control};
         `PFU_OFF_STATUS:    next_prdata = {24'h000000, status_word};
         `PFU_OFF_GAMMA:     next_prdata = {16'h0000, gamma_idx, gamma_lookup_table[gamma_idx]};
         `PFU_OFF_PIX_COUNT: next_prdata = {16'h0000, pix_count};
         default:            next_prdata = 32'h00000000;
      endcase
   end

   // Read data captured in the setup cycle, valid through the access phase
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h00000000;
      end else if (setup && !pwrite) begin
         prdata <= next_prdata;
      end
   end

endmodule

// ===== hdl/pfu_defines.vh
/*
 Constants for the pixel format unpacker: register offsets, field positions,
 depth and format codes. Assumes inclusion by bare name from the design files.
*/
`ifndef PFU_DEFINES_VH
`define PFU_DEFINES_VH

// Register byte offsets
`define PFU_OFF_PANEL_CFG     12'h000
`define PFU_OFF_DISP_MODE     12'h004
`define PFU_OFF_CONTROL       12'h008
`define PFU_OFF_STATUS        12'h00C
`define PFU_OFF_GAMMA         12'h010
`define PFU_OFF_PIX_COUNT     12'h014
`define PFU_ADDR_W            12

// Panel configuration fields
`define PFU_PANEL_KIND_BIT    14
`define PFU_PANEL_TYPE_HI     13
`define PFU_PANEL_TYPE_LO     11
`define PFU_PANEL_TYPE_PASSIVE 3'h2

// Display mode fields
`define PFU_MAIN_DEPTH_HI     2
`define PFU_MAIN_DEPTH_LO     0
`define PFU_OVL1_DEPTH_HI     6
`define PFU_OVL1_DEPTH_LO     4
`define PFU_OVL2_DEPTH_HI     10
`define PFU_OVL2_DEPTH_LO     8
`define PFU_ALPHA_FLAG_BIT    11

// Control fields
`define PFU_CTL_GAMMA_BIT     0
`define PFU_CTL_WIN_HI        5
`define PFU_CTL_WIN_LO        4

// Gamma access fields
`define PFU_GAM_IDX_HI        15
`define PFU_GAM_IDX_LO        8
`define PFU_GAM_VAL_HI        7
`define PFU_GAM_VAL_LO        0
`define PFU_GAM_DEPTH         256

// Window selection codes
`define PFU_WIN_MAIN          2'h0
`define PFU_WIN_OVL1          2'h1
`define PFU_WIN_OVL2          2'h2

// Depth field codes
`define PFU_DEPTH_8           3'h0
`define PFU_DEPTH_16          3'h1
`define PFU_DEPTH_32          3'h2

// Internal format codes
`define PFU_FMT_MONO8         3'h0
`define PFU_FMT_MONO16        3'h1
`define PFU_FMT_MONO32        3'h2
`define PFU_FMT_A1555         3'h3
`define PFU_FMT_A4444         3'h4
`define PFU_FMT_A8888         3'h5
`define PFU_FMT_NONE          3'h7

// Reset values
`define PFU_RST_PANEL_CFG     16'h1000
`define PFU_RST_DISP_MODE     16'h0000
`define PFU_RST_CONTROL       8'h00

`endif

// ===== hdl/pfu_lane.v
/*
 One display lane: takes an 8-bit component and its gamma table entry and
 yields the 6-bit panel value. Assumes the caller has already looked up the
 table with the full 8-bit component.
*/
`include "pfu_defines.vh"

module pfu_lane (
   // Component in
   input  wire [7:0] comp,
   input  wire [7:0] lut_out,
   input  wire       gamma_en,
   // Panel value out
   output wire [5:0] disp
);

   // Low two bits never reach the panel either way
   assign disp = gamma_en ? lut_out[7:2] : comp[7:2]; // RULE_02 RULE_03 RULE_05

endmodule

// ===== dv/pfu_buf_model.sv
/* Display buffer and pixel sink model: serves queued words in order, stalls on demand.
   Assumes the bench fills words and sets slow; one clock shared with the unpacker. */
module pfu_buf_model (
   // Clock and reset
   input  wire         core_clk,
   input  wire         rst,
   // Buffer words
   output logic        word_valid,
   output logic [15:0] word_data,
   input  wire         word_ready,
   // Pixel sink
   output logic        pix_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] words[$];
   logic        slow = 1'b0;

   always @(posedge core_clk) begin
      // Random stalls exercise the hold path
      pix_ready <= !rst && (!slow || $urandom_range(1) == 1);
      if (rst) begin
         word_valid <= 1'b0;
         word_data  <= 16'h0000;
      end else if (!word_valid || word_ready) begin
         if (words.size() != 0 && (!slow || $urandom_range(2) != 0)) begin
            word_valid <= 1'b1;
            word_data  <= words.pop_front();
         end else begin
            // Idle bus must not look like a stale word
            word_valid <= 1'b0;
            word_data  <= ~word_data;
         end
      end
   end
endmodule

// ===== dv/pfu_unpacker_chk.sv
/* Port checker for the unpacker with a shadow of the config registers.
   Assumes config is written only while the pixel stream is idle. */
module pfu_chk (
   // Clock and reset
   input wire        core_clk,
   input wire        rst,
   // APB
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire        pready,
   // Stream
   input wire        word_valid,
   input wire [15:0] word_data,
   input wire        word_ready,
   input wire        pix_valid,
   input wire        pix_ready,
   input wire [7:0]  pix_alpha,
   input wire [7:0]  pix_red,
   input wire [7:0]  pix_green,
   input wire [7:0]  pix_blue,
   input wire [5:0]  disp_red,
   input wire [5:0]  disp_green,
   input wire [5:0]  disp_blue
);
   timeunit 1ns;
   timeprecision 1ps;
   reg  [15:0] cfg, mode, lw;
   reg  [7:0]  ctl, hb;
   wire        wr = psel && penable && pwrite && pready;
   wire [2:0]  dep = ctl[5:4] == 2'h0 ? mode[2:0] : ctl[5:4] == 2'h1 ? mode[6:4] : mode[10:8];
   wire        mono = !cfg[14] && cfg[13:11] == 3'h2 && !(ctl[5:4] == 2'h2 && mode[11]);
   wire        alp = ctl[5:4] == 2'h2 && mode[11] && !mono;
   wire        gam = ctl[0] && cfg[13:11] == 3'h2;
   wire        took = word_valid && word_ready;
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cfg  <= 16'h1000;
         mode <= 16'h0000;
         ctl  <= 8'h00;
      end else if (wr) begin
         if (paddr == 12'h000) cfg <= pwdata[15:0];
         if (paddr == 12'h004) mode <= pwdata[15:0];
         if (paddr == 12'h008) ctl <= pwdata[7:0];
      end
   end
   // Word from the previous cycle and high byte of the last taken word, for the mapping checks
   always @(posedge core_clk) begin
      lw <= word_data;
      if (took) hb <= word_data[15:8];
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   a_pix_hold: assert property (pix_valid && !pix_ready |=> pix_valid &&
      $stable({pix_alpha, pix_red, pix_green, pix_blue, disp_red, disp_green, disp_blue}))
      else $error("pixel changed while stalled");
   a_mono_gray: assert property (pix_valid && mono |-> pix_red == pix_green && pix_blue == pix_red && &pix_alpha)
      else $error("mono pixel not gray");
   a_disp_trunc: assert property (pix_valid && !gam |-> disp_red == pix_red[7:2] && disp_blue == pix_blue[7:2])
      else $error("panel value not truncated");
   a_mono16_map: assert property (took && mono && dep == 3'h1 |=>
      pix_valid && pix_red == {lw[15:13], lw[10:8], lw[4:3]})
      else $error("mono16 gray wrong");
   a_a1555_map: assert property (took && alp && dep == 3'h0 |=>
      pix_valid && pix_alpha == {lw[15], 7'h0} && pix_red == {lw[14:10], 3'h0})
      else $error("1555 unpack wrong");
   a_a4444_map: assert property (took && alp && dep == 3'h1 |=>
      pix_valid && pix_alpha == {lw[15:12], 4'h0} && pix_green == {lw[7:4], 4'h0})
      else $error("4444 unpack wrong");
   a_mono8_even: assert property (took && mono && dep == 3'h0 |=> pix_valid && !word_ready && pix_red == lw[7:0])
      else $error("mono8 even pixel wrong");
   a_mono8_odd: assert property (pix_valid && pix_ready && !word_ready && mono && dep == 3'h0 |=>
      pix_valid && pix_red == hb)
      else $error("mono8 odd pixel wrong");
endmodule
bind pfu_unpacker pfu_chk i_chk (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .word_valid(word_valid),
   .word_data(word_data), .word_ready(word_ready), .pix_valid(pix_valid), .pix_ready(pix_ready),
   .pix_alpha(pix_alpha), .pix_red(pix_red), .pix_green(pix_green), .pix_blue(pix_blue),
   .disp_red(disp_red), .disp_green(disp_green), .disp_blue(disp_blue));

// ===== dv/tb_pixel_format_unpacker.sv
/* Bench for the unpacker: APB config, random words, queued expectations.
   Assumes the buffer model and the bound port checker. */
`include "pfu_defines.vh"
module tb_pixel_format_unpacker;
   timeunit 1ns;
   timeprecision 1ps;
   logic        core_clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   wire         pready, pslverr, word_valid, word_ready, pix_valid, pix_ready;
   wire  [31:0] prdata;
   wire  [15:0] word_data;
   wire  [7:0]  pix_alpha, pix_red, pix_green, pix_blue;
   wire  [5:0]  disp_red, disp_green, disp_blue;
   wire  [49:0] got = {pix_alpha, pix_red, pix_green, pix_blue, disp_red, disp_green, disp_blue};
   int          error_cnt = 0;
   int          samples_checked = 0;
   int          npix = 0;
   logic [49:0] exp_q[$];
   logic [7:0]  gtab[256];
   logic        gam_on = 1'b0;
   logic [31:0] rd;
   logic        err;

   always #4 core_clk = ~core_clk;

   pfu_unpacker i_dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .word_valid(word_valid), .word_data(word_data), .word_ready(word_ready), .pix_valid(pix_valid),
      .pix_ready(pix_ready), .pix_alpha(pix_alpha), .pix_red(pix_red), .pix_green(pix_green),
      .pix_blue(pix_blue), .disp_red(disp_red), .disp_green(disp_green), .disp_blue(disp_blue));
   pfu_buf_model i_buf (.core_clk(core_clk), .rst(rst), .word_valid(word_valid), .word_data(word_data),
      .word_ready(word_ready), .pix_ready(pix_ready));

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
      @(posedge core_clk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the slave
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic check_reg(input logic [11:0] a, input logic [31:0] e, input logic ee);
      apb(1'b0, a, 32'h0);
      samples_checked++;
      if (rd !== e || err !== ee) begin
         error_cnt++;
         $display("FAIL %0t read %h gave %h/%b", $time, a, rd, err);
      end
   endtask
   task automatic check_pix();
      logic [49:0] e;
      e = 50'bx;
      if (exp_q.size() != 0) e = exp_q.pop_front();
      samples_checked++;
      if (got !== e) begin
         error_cnt++;
         $display("FAIL %0t pixel %h expected %h", $time, got, e);
      end
   endtask
   function automatic logic [5:0] dsp(input logic [7:0] c);
      logic [7:0] t;
      t = gam_on ? gtab[c] : c;
      return t[7:2];
   endfunction
   task automatic note(input logic [7:0] a, r, g, b);
      exp_q.push_back({a, r, g, b, dsp(r), dsp(g), dsp(b)});
      npix++;
   endtask
   task automatic gray(input logic [7:0] g);
      note(8'hFF, g, g, g);
   endtask
   task automatic cfg(input logic [15:0] pc, md, input logic [7:0] ct);
      apb(1'b1, `PFU_OFF_PANEL_CFG, {16'h0, pc});
      apb(1'b1, `PFU_OFF_DISP_MODE, {16'h0, md});
      apb(1'b1, `PFU_OFF_CONTROL, {24'h0, ct});
      // Gamma only reaches passive panels
      gam_on = ct[0] && (pc[`PFU_PANEL_TYPE_HI:`PFU_PANEL_TYPE_LO] == `PFU_PANEL_TYPE_PASSIVE);
   endtask
   // Waits until every word is taken and every pixel seen
   task automatic send(input logic [2:0] fmt, input int n);
      logic [15:0] w, v;
      int k;
      k = 0;
      repeat (n) begin
         w = 16'($urandom);
         v = 16'($urandom);
         i_buf.words.push_back(w);
         if (fmt == `PFU_FMT_MONO32 || fmt == `PFU_FMT_A8888) i_buf.words.push_back(v);
         case (fmt)
            `PFU_FMT_MONO8: begin
               gray(w[7:0]);
               gray(w[15:8]);
            end
            `PFU_FMT_MONO16: gray({w[15:13], w[10:8], w[4:3]});
            `PFU_FMT_MONO32: gray({v[7:5], w[15:13], w[7:6]});
            `PFU_FMT_A1555: note({w[15], 7'h0}, {w[14:10], 3'h0}, {w[9:5], 3'h0}, {w[4:0], 3'h0});
            `PFU_FMT_A4444: note({w[15:12], 4'h0}, {w[11:8], 4'h0}, {w[7:4], 4'h0}, {w[3:0], 4'h0});
            `PFU_FMT_A8888: note(v[15:8], v[7:0], w[15:8], w[7:0]);
            default: note(8'h00, 8'h00, 8'h00, 8'h00);
         endcase
      end
      while ((i_buf.words.size() != 0 || exp_q.size() != 0) && k < 3000) begin
         @(posedge core_clk);
         k++;
      end
      if (k >= 3000) begin
         error_cnt++;
         $display("FAIL %0t stream stalled", $time);
      end
   endtask
   task automatic complete_run();
      $display("error_cnt=%0d samples_checked=%0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   always @(posedge core_clk) if (!rst && pix_valid === 1'b1 && pix_ready === 1'b1) check_pix();

   initial begin
      #100us;
      error_cnt++;
      $display("FAIL %0t watchdog expired", $time);
      complete_run();
   end

   initial begin
      rd = $urandom(64468);
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      check_reg(`PFU_OFF_PANEL_CFG, 32'h1000, 1'b0);
      check_reg(`PFU_OFF_DISP_MODE, 32'h0, 1'b0);
      check_reg(`PFU_OFF_STATUS, 32'h20, 1'b0);
      check_reg(12'h040, 32'h0, 1'b1);
      i_buf.slow = 1'b1;
      send(`PFU_FMT_MONO8, 6);
      cfg(16'h1000, 16'h0001, 8'h00);
      send(`PFU_FMT_MONO16, 6);
      cfg(16'h1000, 16'h0002, 8'h00);
      send(`PFU_FMT_MONO32, 6);
      cfg(16'h1000, 16'h0020, 8'h10);
      send(`PFU_FMT_MONO32, 4);
      for (int i = 0; i < 256; i++) begin
         gtab[i] = 8'($urandom);
         apb(1'b1, `PFU_OFF_GAMMA, {16'h0, 8'(i), gtab[i]});
      end
      check_reg(`PFU_OFF_GAMMA, {16'h0, 8'hFF, gtab[255]}, 1'b0);
      cfg(16'h1000, 16'h0000, 8'h01);
      send(`PFU_FMT_MONO8, 6);
      for (int f = 0; f < 3; f++) begin
         cfg(16'h5000, {4'h0, 1'b1, f[2:0], 8'h00}, 8'h20);
         check_reg(`PFU_OFF_STATUS, 32'(8'h13 + f), 1'b0);
         send(3'(3 + f), 6);
      end
      cfg(16'h5000, 16'h0A00, 8'h21);
      send(`PFU_FMT_A8888, 4);
      cfg(16'h5000, 16'h0100, 8'h20);
      send(`PFU_FMT_NONE, 3);
      cfg(16'h4000, 16'h0000, 8'h01);
      check_reg(`PFU_OFF_STATUS, 32'h07, 1'b0);
      send(`PFU_FMT_NONE, 2);
      i_buf.slow = 1'b0;
      cfg(16'h1000, 16'h0000, 8'h00);
      send(`PFU_FMT_MONO8, 8);
      check_reg(`PFU_OFF_PIX_COUNT, 32'(npix), 1'b0);
      complete_run();
   end
endmodule
